// ### sim/apfh_assertions.sv
// checker: fault handler port timing
`timescale 1ns/1ps
module apfh_assertions (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic amp_reset_n_i,
    input wire apfh_pkg::apfh_sense_type sense_i,
    input wire apfh_pkg::apfh_bus_type bus_i,
    input wire logic [31:0] rdata_o,
    input wire logic [3:0] bridge_hiz_o,
    input wire logic [1:0] pwm_en_o,
    input wire logic fault_n_oe_n_o,
    input wire logic clip_heat_warn_n_oe_n_o
);
    import apfh_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] age_reg;
    logic ran_reg;
    // $past looks up to four edges back, so hold off after reset
    wire ok = age_reg == 3'h7;
    wire hiz = &bridge_hiz_o;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            age_reg <= 3'h0;
            ran_reg <= 1'b0;
        end else begin
            age_reg <= ok ? age_reg : age_reg + 3'h1;
            ran_reg <= ran_reg | (|pwm_en_o);
        end
    end
    warn_follow_a: assert property (
        ok |-> clip_heat_warn_n_oe_n_o == !$past(sense_i.temp_warn, 3))
        else $error("warning line wrong");
    reset_force_a: assert property (
        ran_reg && !amp_reset_n_i && !$past(amp_reset_n_i)
        |=> fault_n_oe_n_o && hiz) else $error("reset low not obeyed");
    uv_off_a: assert property (
        ok && amp_reset_n_i && $past(amp_reset_n_i) &&
        $past(amp_reset_n_i, 2) &&
        ($past(sense_i.core_uv, 3) || $past(sense_i.gate_uv, 3))
        |-> hiz && !fault_n_oe_n_o) else $error("undervoltage missed");
    stuck_off_a: assert property (
        ok && $past(sense_i.osc_stuck, 3) |-> hiz) else $error("stuck missed");
    drive_pair_a: assert property (
        (pwm_en_o & {|bridge_hiz_o[3:2], |bridge_hiz_o[1:0]}) == 2'h0)
        else $error("running channel in Hi-Z");
    // channel path has the latch stage too, so four edges, not three
    chan_stop_a: assert property (
        ok |-> ($past(sense_i.chan_flt, 4) & pwm_en_o) == 2'h0)
        else $error("faulted channel runs");
    shut_latch_a: assert property (
        (ran_reg && ok && $past(sense_i.temp_shut, 3) && amp_reset_n_i &&
        $past(amp_reset_n_i) && $past(amp_reset_n_i, 2))
        ##1 amp_reset_n_i [*6] |-> hiz && !fault_n_oe_n_o)
        else $error("shutdown not latched");
    bad_read_a: assert property (
        $past(bus_i.rd) && $past(bus_i.addr) > 4'h3 |-> rdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule : apfh_assertions
bind apfh_top apfh_assertions chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .amp_reset_n_i(amp_reset_n_i), .sense_i(sense_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .bridge_hiz_o(bridge_hiz_o), .pwm_en_o(pwm_en_o),
    .fault_n_oe_n_o(fault_n_oe_n_o),
    .clip_heat_warn_n_oe_n_o(clip_heat_warn_n_oe_n_o));

// ### sim/apfh_ctrl_model.sv
// partner: system controller driving the amplifier reset pin
`timescale 1ns/1ps
module apfh_ctrl_model #(
    parameter int HOLD_CYC = apfh_pkg::APFH_RESET_HOLD_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic fault_n_i,
    input wire logic warn_n_i,
    input wire logic hold_i,
    output logic amp_reset_n_o
);
    int gap;
    logic fault_d;
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap <= HOLD_CYC;
            fault_d <= 1'b1;
            amp_reset_n_o <= 1'b0;
        end else begin
            fault_d <= fault_n_i;
            gap <= (fault_d && !fault_n_i) ? 0 : gap + (gap < HOLD_CYC);
            if (hold_i) amp_reset_n_o <= 1'b0;
            // never release into a hot device or too soon after a fault
            else if (gap >= HOLD_CYC && warn_n_i)
                amp_reset_n_o <= 1'b1;
        end
    end
endmodule : apfh_ctrl_model

// ### sim/tb.sv
// testbench: short check, thermal, supply, channel faults, registers
`timescale 1ns/1ps
module tb;
    import apfh_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sup_ok = 1'b0;
    logic hold = 1'b0;
    logic [1:0] cfg = APFH_CFG_BRIDGE;
    apfh_sense_type sense = '0;
    apfh_bus_type bus = '0;
    logic amp_rst_n, irq, flt, flt_oe_n, wrn, wrn_oe_n;
    logic [31:0] rdata, d;
    logic [3:0] hiz;
    logic [1:0] pwm;
    int miscompares = 0, cmp_count = 0, seed = 32'hd101;
    always #25 core_clk_i = ~core_clk_i;
    apfh_top uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .amp_reset_n_i(amp_rst_n), .core_supply_ok_i(sup_ok),
        .out_cfg_i(cfg), .sense_i(sense), .bus_i(bus), .rdata_o(rdata),
        .irq_o(irq), .bridge_hiz_o(hiz), .pwm_en_o(pwm), .fault_n_o(flt),
        .fault_n_oe_n_o(flt_oe_n), .clip_heat_warn_n_o(wrn),
        .clip_heat_warn_n_oe_n_o(wrn_oe_n));
    // both open-drain lines have pull-ups
    apfh_ctrl_model #(.HOLD_CYC(8)) ctrl (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .fault_n_i(flt_oe_n | flt), .warn_n_i(wrn_oe_n | wrn),
        .hold_i(hold), .amp_reset_n_o(amp_rst_n));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : wt
    // read data is taken at the edge that closes its one-cycle window
    task bus_op(input logic w, input logic [3:0] a, input logic [31:0] v);
        wt(1);
        bus <= '{addr: a, wdata: v, wr: w, rd: !w};
        wt(1);
        bus <= '0;
        wt(1);
        d = rdata;
    endtask : bus_op
    function automatic logic [5:0] run_exp(input logic [1:0] run);
        return {run, {2{!run[1]}}, {2{!run[0]}}};
    endfunction : run_exp
    task look(input logic [1:0] run, input logic fo, input logic [4:0] st);
        chk({pwm, hiz, flt_oe_n}, {run_exp(run), fo});
        bus_op(0, APFH_ADDR_STATE, 0);
        chk(d[4:0], st);
    endtask : look
    task toggle;
        hold <= 1'b1;
        wt(4);
        chk(flt_oe_n, 1'b1);
        hold <= 1'b0;
        wt(20);
    endtask : toggle
    task results;
        if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    initial begin
        sense.short_gnd <= 1'b1;
        wt(20);
        rst_i <= 1'b0;
        sup_ok <= 1'b1;
        wt(10);
        hold <= 1'b1;
        wt(3);
        look(2'h0, 1'b0, APFH_ST_GND);
        sense <= '{short_sup: 1'b1, default: 1'b0};
        wt(10);
        look(2'h0, 1'b0, APFH_ST_SUP);
        hold <= 1'b0;
        sense.short_sup <= 1'b0;
        wt(20);
        look(2'h3, 1'b1, APFH_ST_RUN);
        // a late short stays present to the end
        sense.short_gnd <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            sense.temp_warn <= (i == 0) || ($random(seed) % 2 != 0);
            wt(5);
            chk(wrn_oe_n, !sense.temp_warn);
            look(2'h3, 1'b1, APFH_ST_RUN);
        end
        sense.temp_warn <= 1'b0;
        for (int c = 0; c < 2; c++) begin
            sense.chan_flt <= 2'h1 << c;
            wt(5);
            sense.chan_flt <= 2'h0;
            wt(5);
            look(2'h2 >> c, 1'b0, APFH_ST_RUN);
            toggle();
            look(2'h3, 1'b1, APFH_ST_RUN);
        end
        sense.temp_shut <= 1'b1;
        wt(5);
        sense.temp_shut <= 1'b0;
        wt(5);
        look(2'h0, 1'b0, APFH_ST_LATCH);
        toggle();
        look(2'h3, 1'b1, APFH_ST_RUN);
        for (int k = 0; k < 3; k++) begin
            {sense.core_uv, sense.gate_uv, sense.osc_stuck} <= 3'h4 >> k;
            wt(5);
            look(2'h0, k == 2, APFH_ST_RUN);
            {sense.core_uv, sense.gate_uv, sense.osc_stuck} <= 3'h0;
            wt(5);
            look(2'h3, 1'b1, APFH_ST_RUN);
        end
        bus_op(0, APFH_ADDR_STATUS, 0);
        chk({irq, d[5:0]}, {1'b0, 6'h3f});
        bus_op(1, APFH_ADDR_MASK, 32'h0000_003f);
        wt(2);
        chk(irq, 1'b1);
        bus_op(1, APFH_ADDR_STATUS, 32'h0000_003f);
        bus_op(0, APFH_ADDR_STATUS, 0);
        chk({irq, d[5:0]}, 7'h00);
        bus_op(0, 4'hf, 0);
        chk(d, 32'h0000_0000);
        rst_i <= 1'b1;
        cfg <= APFH_CFG_SINGLE;
        wt(2);
        rst_i <= 1'b0;
        wt(10);
        look(2'h3, 1'b1, APFH_ST_RUN);
        bus_op(0, APFH_ADDR_CONFIG, 0);
        chk(d[1:0], APFH_CFG_SINGLE);
        results();
    end
    initial begin
        wt(3000);
        miscompares++;
        results();
    end
endmodule : tb

// ### verilog/apfh_pkg.sv
// package: constants and carriers for the amp protection fault handler
package apfh_pkg;

    localparam int APFH_NUM_CH = 2;
    localparam int APFH_NUM_HB = 4;

    // output configurations
    localparam logic [1:0] APFH_CFG_BRIDGE = 2'h0;
    localparam logic [1:0] APFH_CFG_PARALLEL = 2'h1;
    localparam logic [1:0] APFH_CFG_SINGLE = 2'h2;

    // clock and minimum reset-hold interval after the fault falls
    localparam int APFH_CLK_HZ = 20000000;
    localparam int APFH_RESET_HOLD_US = 4000;
    localparam int APFH_RESET_HOLD_CYC =
        (APFH_RESET_HOLD_US * (APFH_CLK_HZ / 1000000));

    // status and mask bit positions
    localparam int APFH_EV_SHORT = 0;
    localparam int APFH_EV_WARN = 1;
    localparam int APFH_EV_SHUT = 2;
    localparam int APFH_EV_UV = 3;
    localparam int APFH_EV_CHAN = 4;
    localparam int APFH_EV_STUCK = 5;
    localparam int APFH_EV_W = 6;

    // register offsets
    localparam logic [3:0] APFH_ADDR_STATUS = 4'h0;
    localparam logic [3:0] APFH_ADDR_MASK = 4'h1;
    localparam logic [3:0] APFH_ADDR_STATE = 4'h2;
    localparam logic [3:0] APFH_ADDR_CONFIG = 4'h3;

    localparam logic [5:0] APFH_MASK_RST = 6'h00;
    localparam logic [1:0] APFH_CONFIG_RST = 2'h0;

    // analog comparator indications, asynchronous to the core clock
    typedef struct packed {
        logic short_gnd;
        logic short_sup;
        logic temp_warn;
        logic temp_shut;
        logic core_uv;
        logic gate_uv;
        logic osc_stuck;
        logic [1:0] chan_flt;
    } apfh_sense_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } apfh_bus_type;

    typedef enum logic [4:0] {
        APFH_ST_WAIT = 5'h01,
        APFH_ST_GND = 5'h02,
        APFH_ST_SUP = 5'h04,
        APFH_ST_RUN = 5'h08,
        APFH_ST_LATCH = 5'h10
    } apfh_state_type;

endpackage : apfh_pkg

// ### verilog/apfh_top.sv
// amp protection fault handler: startup short check and fault control
//
// Summary of operation
// - short check only at core supply startup
// - hold bridges Hi-Z while short persists
// - check ground shorts, then supply shorts
// - fault low, reset ignored during check
// - later resets never rerun short check
// - skip short check in single-ended mode
// - warning line low above warning temperature
// - shutdown temperature latches Hi-Z until reset
// - undervoltage forces Hi-Z, self recovers
// - global fault latches, cleared by reset
// - channel fault stops only that channel
// - reset low forces fault line high
// - thermal warning clears itself when cooled
// - oscillator stuck gives silent global Hi-Z
// - fault and warning are open-drain, active low
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module apfh_top (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic amp_reset_n_i,
    input wire logic core_supply_ok_i,
    input wire logic [1:0] out_cfg_i,
    input wire apfh_pkg::apfh_sense_type sense_i,
    input wire apfh_pkg::apfh_bus_type bus_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    output logic [3:0] bridge_hiz_o,
    output logic [1:0] pwm_en_o,
    output logic fault_n_o,
    output logic fault_n_oe_n_o,
    output logic clip_heat_warn_n_o,
    output logic clip_heat_warn_n_oe_n_o
);
    import apfh_pkg::*;

    // two-flop synchronisers, one per comparator bit
    localparam int SW = $bits(apfh_sense_type);
    logic [SW-1:0] sync1_reg, sync2_reg;
    logic [SW-1:0] sync1_next, sync2_next;
    apfh_sense_type sense_s;

    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_comb begin
                sync1_next[gi] = sense_i[gi];
                sync2_next[gi] = sync1_reg[gi];
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end
    assign sense_s = sync2_reg;

    // reset input edge detection (reset pin is synchronous)
    logic amp_rst_d_reg, amp_rst_d_next;
    logic amp_rise;
    assign amp_rise = amp_reset_n_i & ~amp_rst_d_reg;

    // sequencer and latched faults
    apfh_state_type state_reg, state_next;
    logic glob_latch_reg, glob_latch_next;
    logic [1:0] chan_latch_reg, chan_latch_next;
    logic uv_now;
    assign uv_now = sense_s.core_uv | sense_s.gate_uv;

    always_comb begin
        state_next = state_reg;
        glob_latch_next = glob_latch_reg;
        chan_latch_next = chan_latch_reg;
        amp_rst_d_next = amp_reset_n_i;
        case (state_reg)
            APFH_ST_WAIT: begin
                // check runs once, when the core supply first comes up
                if (core_supply_ok_i && !uv_now) begin
                    if (out_cfg_i == APFH_CFG_SINGLE) begin
                        state_next = APFH_ST_RUN;
                    end else begin
                        state_next = APFH_ST_GND;
                    end
                end
            end
            APFH_ST_GND: begin
                // stays here while a ground short persists
                if (!sense_s.short_gnd) begin
                    state_next = APFH_ST_SUP;
                end
            end
            APFH_ST_SUP: begin
                if (sense_s.short_gnd) begin
                    state_next = APFH_ST_GND;
                end else if (!sense_s.short_sup) begin
                    state_next = APFH_ST_RUN;
                end
            end
            APFH_ST_RUN: begin
                // no path back to the check states afterwards
                if (sense_s.temp_shut) begin
                    glob_latch_next = 1'b1;
                    state_next = APFH_ST_LATCH;
                end
                chan_latch_next = chan_latch_reg | sense_s.chan_flt;
                if (amp_rise) begin
                    chan_latch_next = sense_s.chan_flt;
                end
            end
            APFH_ST_LATCH: begin
                // only a rising reset edge leaves, temp permitting
                if (amp_rise && !sense_s.temp_shut) begin
                    glob_latch_next = 1'b0;
                    chan_latch_next = sense_s.chan_flt;
                    state_next = APFH_ST_RUN;
                end else begin
                    chan_latch_next = chan_latch_reg | sense_s.chan_flt;
                end
            end
            default: begin
                state_next = APFH_ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= APFH_ST_WAIT;
            glob_latch_reg <= 1'b0;
            chan_latch_reg <= 2'h0;
            amp_rst_d_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            glob_latch_reg <= glob_latch_next;
            chan_latch_reg <= chan_latch_next;
            amp_rst_d_reg <= amp_rst_d_next;
        end
    end

    // output control
    logic checking;
    logic run_ok;
    logic [3:0] hiz_next, hiz_reg;
    logic [1:0] pwm_next, pwm_reg;
    logic fault_next, fault_reg;
    logic warn_next, warn_reg;

    assign checking = (state_reg == APFH_ST_GND) ||
                      (state_reg == APFH_ST_SUP);

    always_comb begin
        // stuck oscillator silences all outputs yet never pulls the fault line low
        run_ok = (state_reg == APFH_ST_RUN) && !uv_now &&
                 !sense_s.osc_stuck && amp_reset_n_i;
        for (int c = 0; c < APFH_NUM_CH; c++) begin
            pwm_next[c] = run_ok && !chan_latch_reg[c];
            hiz_next[2*c] = !pwm_next[c];
            hiz_next[2*c+1] = !pwm_next[c];
        end
        // the check overrides the reset pin's fault-line mask
        if (checking) begin
            fault_next = 1'b0;
        end else if (!amp_reset_n_i) begin
            fault_next = 1'b1;
        end else begin
            fault_next = !(glob_latch_reg || (|chan_latch_reg) ||
                           uv_now);
        end
        warn_next = !sense_s.temp_warn;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hiz_reg <= 4'hf;
            pwm_reg <= 2'h0;
            fault_reg <= 1'b1;
            warn_reg <= 1'b1;
        end else begin
            hiz_reg <= hiz_next;
            pwm_reg <= pwm_next;
            fault_reg <= fault_next;
            warn_reg <= warn_next;
        end
    end

    // interrupt status, mask and register port
    logic [APFH_EV_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
    logic [APFH_EV_W-1:0] ev;
    logic [31:0] rdata_next, rdata_reg;
    logic irq_next, irq_reg;

    always_comb begin
        ev = '0;
        ev[APFH_EV_SHORT] = checking;
        ev[APFH_EV_WARN] = sense_s.temp_warn;
        ev[APFH_EV_SHUT] = glob_latch_reg;
        ev[APFH_EV_UV] = uv_now;
        ev[APFH_EV_CHAN] = |chan_latch_reg;
        ev[APFH_EV_STUCK] = sense_s.osc_stuck;
        stat_next = stat_reg;
        mask_next = mask_reg;
        if (bus_i.wr && bus_i.addr == APFH_ADDR_STATUS) begin
            stat_next = stat_reg & ~bus_i.wdata[APFH_EV_W-1:0];
        end else if (bus_i.wr && bus_i.addr == APFH_ADDR_MASK) begin
            mask_next = bus_i.wdata[APFH_EV_W-1:0];
        end
        // a new event wins over a clear in the same cycle
        stat_next = stat_next | ev;
        rdata_next = 32'h0000_0000;
        if (bus_i.rd) begin
            if (bus_i.addr == APFH_ADDR_STATUS) begin
                rdata_next[APFH_EV_W-1:0] = stat_reg;
            end else if (bus_i.addr == APFH_ADDR_MASK) begin
                rdata_next[APFH_EV_W-1:0] = mask_reg;
            end else if (bus_i.addr == APFH_ADDR_STATE) begin
                rdata_next[4:0] = state_reg;
                rdata_next[6:5] = chan_latch_reg;
                rdata_next[7] = glob_latch_reg;
            end else if (bus_i.addr == APFH_ADDR_CONFIG) begin
                rdata_next[1:0] = out_cfg_i;
            end
        end
        irq_next = |(stat_next & mask_next);
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_reg <= '0;
            mask_reg <= APFH_MASK_RST;
            rdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    // open-drain: enable low drives the pin low, value always 0
    assign rdata_o = rdata_reg;
    assign irq_o = irq_reg;
    assign bridge_hiz_o = hiz_reg;
    assign pwm_en_o = pwm_reg;
    assign fault_n_o = 1'b0;
    assign fault_n_oe_n_o = fault_reg;
    assign clip_heat_warn_n_o = 1'b0;
    assign clip_heat_warn_n_oe_n_o = warn_reg;

endmodule : apfh_top
